// ### prt_pkg.sv
/*
  Constants, register map and carrier types of the prescaled reload timer.
  Assumes a single 40 MHz system clock and an APB register bus.
*/
package prt_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int CNT_W  = 8;

  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_CONTROL   = 10'h108;
  localparam logic [9:0] IDX_ONESHOT   = 10'h109;
  localparam logic [9:0] IDX_IO_CTRL   = 10'h10a;
  localparam logic [9:0] IDX_MODE      = 10'h10b;
  localparam logic [9:0] IDX_PRESCALER = 10'h10c;
  localparam logic [9:0] IDX_SECONDARY = 10'h10d;
  localparam logic [9:0] IDX_PRIMARY   = 10'h10e;
  localparam logic [9:0] IDX_IRQ_STAT  = 10'h110;
  localparam logic [9:0] IDX_IRQ_MASK  = 10'h111;

  // control register fields
  localparam int CTL_START_BIT  = 0;
  localparam int CTL_STATUS_BIT = 1;
  localparam int CTL_FSTOP_BIT  = 2;
  // mode register fields
  localparam int MODE_WTS_BIT = 3;
  localparam int MODE_SRC_LO  = 4;
  // irq status / mask field
  localparam int IRQ_UFLOW_BIT = 0;
  localparam int IO_CTRL_W     = 4;

  localparam logic [7:0] PRIMARY_RST   = 8'hff;
  localparam logic [7:0] PRESCALER_RST = 8'hff;
  localparam logic [7:0] SECONDARY_RST = 8'hff;
  localparam logic [7:0] REG8_RST      = 8'h00;

  localparam logic [2:0] DIV8_LAST = 3'h7;

  typedef enum logic [1:0] {
    SRC_UNDIVIDED = 2'b00,
    SRC_HALF      = 2'b01,
    SRC_EIGHTH    = 2'b10,
    SRC_COMPANION = 2'b11
  } prt_src_t;

  typedef struct packed {
    logic       wr_en;
    logic       both;
    logic [7:0] data;
  } prt_stage_wr_t;
endpackage

// ### prt_src_sel.sv
/*
  Count source selection: one-cycle enables at full, half or eighth
  clock rate, or the companion timer underflow.
  Assumes the companion pulse is one cycle.
*/
`timescale 1ns/10ps
`default_nettype none
module prt_src_sel
  import prt_pkg::*;
(
  input  wire logic     clk,        // system clock
  input  wire logic     rst,        // async reset, high
  input  wire logic     run,        // counting enabled
  input  wire prt_src_t sel,        // chosen source
  input  wire logic     comp_uflow, // companion underflow pulse
  output logic          tick        // count source enable
);
  logic [2:0] div_q;
  wire        half_w   = div_q[0];
  wire        eighth_w = (div_q == DIV8_LAST);

  // divider only runs while counting so the first tick is predictable
  always_ff @(posedge clk or posedge rst) begin
    if (rst) div_q <= 3'h0;
    else if (run) div_q <= div_q + 3'h1;
    else div_q <= 3'h0;
  end

  always_comb begin
    case (sel)
      SRC_UNDIVIDED: tick = 1'b1;
      SRC_HALF:      tick = half_w;
      SRC_EIGHTH:    tick = eighth_w;
      SRC_COMPANION: tick = comp_uflow;
      default:       tick = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// ### prt_stage.sv
/*
  One reload down-counter stage. Assumes tick is a one-cycle enable and
  writes arrive as one-cycle strobes.
*/
`timescale 1ns/10ps
`default_nettype none
module prt_stage
  import prt_pkg::*;
#(
  parameter logic [7:0] RST_VAL = 8'hff
)(
  input  wire logic          clk,   // system clock
  input  wire logic          rst,   // async reset, high
  input  wire logic          run,   // counting enabled
  input  wire logic          tick,  // stage count enable
  input  wire prt_stage_wr_t wr,    // software write
  output logic [7:0]         cnt,   // current count
  output logic               uflow  // underflow pulse
);
  logic [7:0] reload_q;
  logic [7:0] cnt_q;
  logic       pend_q;

  wire step_w = run & tick & ~wr.wr_en;
  wire zero_w = (cnt_q == 8'h00);

  assign cnt   = cnt_q;
  assign uflow = step_w & ~pend_q & zero_w;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reload_q <= RST_VAL;
      cnt_q    <= RST_VAL;
      pend_q   <= 1'b0;
    end else if (wr.wr_en && !run) begin
      reload_q <= wr.data;
      cnt_q    <= wr.data;
      pend_q   <= 1'b0;
    end else if (wr.wr_en) begin
      reload_q <= wr.data;
      pend_q   <= wr.both;
    end else if (step_w) begin
      // a pending load takes the tick instead of a decrement
      if (pend_q) begin
        cnt_q  <= reload_q;
        pend_q <= 1'b0;
      end else if (zero_w) begin
        cnt_q <= reload_q;
      end else begin
        cnt_q <= cnt_q - 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ### prt_timer.sv
/*
  Prescaled reload down timer, timer mode, with APB register access and
  a masked level interrupt. Assumes one 40 MHz clock and an APB master.
*/
// Added by the designer: the APB register port.
`timescale 1ns/10ps
`default_nettype none
module prt_timer
  import prt_pkg::*;
(
  input  wire logic              sys_clk,    // 40 MHz system clock
  input  wire logic              rst,        // async reset, high
  input  wire logic [ADDR_W-1:0] paddr,      // apb byte address
  input  wire logic              psel,       // apb select
  input  wire logic              penable,    // apb access phase
  input  wire logic              pwrite,     // apb write
  input  wire logic [DATA_W-1:0] pwdata,     // apb write data
  output logic      [DATA_W-1:0] prdata,     // apb read data
  output logic                   pready,     // apb ready
  output logic                   pslverr,    // apb error
  input  wire logic              comp_uflow, // companion underflow
  output logic                   irq         // level interrupt
);
  logic       start_q;
  logic [7:0] oneshot_q;
  logic [7:0] secondary_q;
  logic [IO_CTRL_W-1:0] io_ctrl_q;
  logic [7:0] mode_q;
  logic       stat_q;
  logic       mask_q;
  logic [DATA_W-1:0] prdata_q;
  logic       pready_q;
  logic       pslverr_q;
  logic       irq_q;

  // bus decode
  wire [9:0] idx_w   = paddr[ADDR_W-1:2];
  wire       setup_w = psel & ~penable;
  wire       wr_w    = psel & penable & pwrite & pready_q;
  wire [7:0] wb_w    = pwdata[7:0];

  wire hit_ctl  = (idx_w == IDX_CONTROL);
  wire hit_one  = (idx_w == IDX_ONESHOT);
  wire hit_io   = (idx_w == IDX_IO_CTRL);
  wire hit_mode = (idx_w == IDX_MODE);
  wire hit_pre  = (idx_w == IDX_PRESCALER);
  wire hit_sec  = (idx_w == IDX_SECONDARY);
  wire hit_pri  = (idx_w == IDX_PRIMARY);
  wire hit_stat = (idx_w == IDX_IRQ_STAT);
  wire hit_mask = (idx_w == IDX_IRQ_MASK);
  wire mapped_w = hit_ctl | hit_one | hit_io | hit_mode | hit_pre |
                  hit_sec | hit_pri | hit_stat | hit_mask;

  // counting engine
  wire       run_w = start_q;
  wire       wts_w = mode_q[MODE_WTS_BIT];
  wire       src_tick_w;
  wire       pre_uflow_w;
  wire       tmr_uflow_w;
  wire [7:0] pre_cnt_w;
  wire [7:0] tmr_cnt_w;
  wire prt_src_t src_w = prt_src_t'(mode_q[MODE_SRC_LO +: 2]);

  wire prt_stage_wr_t pre_wr_w = '{wr_en: wr_w & hit_pre,
                                   both:  ~wts_w, data: wb_w};
  wire prt_stage_wr_t tmr_wr_w = '{wr_en: wr_w & hit_pri,
                                   both:  ~wts_w, data: wb_w};

  prt_src_sel u_src (
    .clk        (sys_clk),
    .rst        (rst),
    .run        (run_w),
    .sel        (src_w),
    .comp_uflow (comp_uflow),
    .tick       (src_tick_w)
  );

  prt_stage #(.RST_VAL(PRESCALER_RST)) u_pre (
    .clk   (sys_clk),
    .rst   (rst),
    .run   (run_w),
    .tick  (src_tick_w),
    .wr    (pre_wr_w),
    .cnt   (pre_cnt_w),
    .uflow (pre_uflow_w)
  );

  // timer stage is clocked only by prescaler underflows
  prt_stage #(.RST_VAL(PRIMARY_RST)) u_tmr (
    .clk   (sys_clk),
    .rst   (rst),
    .run   (run_w),
    .tick  (pre_uflow_w),
    .wr    (tmr_wr_w),
    .cnt   (tmr_cnt_w),
    .uflow (tmr_uflow_w)
  );

  // read mux; one-shot and secondary are stored only, no effect here
  logic [7:0] rd8_w;
  always_comb begin
    rd8_w = 8'h00;
    if (hit_ctl) begin
      rd8_w[CTL_START_BIT]  = start_q;
      rd8_w[CTL_STATUS_BIT] = start_q;
    end
    if (hit_one)  rd8_w = oneshot_q;
    if (hit_io)   rd8_w = {{(8-IO_CTRL_W){1'b0}}, io_ctrl_q};
    if (hit_mode) rd8_w = mode_q;
    if (hit_pre)  rd8_w = pre_cnt_w;
    if (hit_sec)  rd8_w = secondary_q;
    if (hit_pri)  rd8_w = tmr_cnt_w;
    if (hit_stat) rd8_w[IRQ_UFLOW_BIT] = stat_q;
    if (hit_mask) rd8_w[IRQ_UFLOW_BIT] = mask_q;
  end

  // no wait state: data and ready registered in setup phase
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prdata_q  <= '0;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= setup_w;
      pslverr_q <= setup_w & ~mapped_w;
      if (setup_w) prdata_q <= {{(DATA_W-8){1'b0}}, rd8_w};
    end
  end

  // start bit: forced stop wins over a start in the same write
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) start_q <= 1'b0;
    else if (wr_w && hit_ctl) begin
      if (wb_w[CTL_FSTOP_BIT]) start_q <= 1'b0;
      else start_q <= wb_w[CTL_START_BIT];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      oneshot_q   <= REG8_RST;
      secondary_q <= SECONDARY_RST;
      io_ctrl_q   <= '0;
      mode_q      <= REG8_RST;
      mask_q      <= 1'b0;
    end else if (wr_w) begin
      if (hit_one)  oneshot_q   <= wb_w;
      if (hit_sec)  secondary_q <= wb_w;
      // output level select kept at zero by software in this mode
      if (hit_io)   io_ctrl_q   <= wb_w[IO_CTRL_W-1:0];
      if (hit_mode) mode_q      <= wb_w;
      if (hit_mask) mask_q      <= wb_w[IRQ_UFLOW_BIT];
    end
  end

  // sticky underflow flag, write one to clear; a new event wins
  wire clr_w = wr_w & hit_stat & wb_w[IRQ_UFLOW_BIT];
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stat_q <= 1'b0;
      irq_q  <= 1'b0;
    end else begin
      stat_q <= tmr_uflow_w | (stat_q & ~clr_w);
      irq_q  <= (tmr_uflow_w | (stat_q & ~clr_w)) & mask_q;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign irq     = irq_q;
endmodule
`default_nettype wire

// ### prt_timer_chk.sv
/* Port checker for prt_timer, bound at the foot of this file.
   Assumes the package register indices and word addressing. */
`timescale 1ns/10ps
`default_nettype none
module prt_timer_chk
  import prt_pkg::*;
(
  input wire logic              sys_clk,    // clock
  input wire logic              rst,        // reset
  input wire logic [ADDR_W-1:0] paddr,      // address
  input wire logic              psel,       // select
  input wire logic              penable,    // access
  input wire logic              pwrite,     // write
  input wire logic [DATA_W-1:0] pwdata,     // wdata
  input wire logic [DATA_W-1:0] prdata,     // rdata
  input wire logic              pready,     // ready
  input wire logic              pslverr,    // error
  input wire logic              comp_uflow, // companion
  input wire logic              irq         // interrupt
);
  wire logic [9:0] idx;
  wire logic       mapped;
  wire logic       rd_acc;
  assign idx = paddr[11:2];
  assign mapped = (idx >= IDX_CONTROL && idx <= IDX_PRIMARY) ||
                  idx == IDX_IRQ_STAT || idx == IDX_IRQ_MASK;
  assign rd_acc = pready && !pwrite;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_err_unmapped: assert property (pready |-> pslverr == !mapped)
    else $error("pslverr wrong for address");
  a_err_no_data: assert property (pslverr |-> prdata == 32'h0)
    else $error("data on error");
  a_rdata_upper_zero: assert property (rd_acc |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_io_upper_zero: assert property (
    rd_acc && idx == IDX_IO_CTRL |-> prdata[7:4] == 4'h0)
    else $error("io control upper nibble set");
  a_mask_off_irq: assert property (
    pready && pwrite && idx == IDX_IRQ_MASK && !pwdata[0] |-> ##2 !irq)
    else $error("irq with mask clear");
  a_quiet_after_reset: assert property ($fell(rst) |-> !irq [*2])
    else $error("irq right after reset");

  cover property (rd_acc && idx == IDX_PRIMARY);
  cover property ($rose(irq));
  cover property (pslverr);
endmodule

bind prt_timer prt_timer_chk prt_timer_chk_inst (
  .sys_clk(sys_clk), .rst(rst), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .comp_uflow(comp_uflow), .irq(irq));
`default_nettype wire

// ### prt_timer_test.sv
/* Self-checking bench for prt_timer over APB.
   Assumes the package map and a 25 ns system clock. */
`timescale 1ns/10ps
`default_nettype none
module prt_timer_test;
  import prt_pkg::*;
  logic              sys_clk, rst, psel, penable, pwrite, comp_uflow;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rv, v;
  logic              pready, pslverr, irq, re;
  int                error_cnt, samples_checked;

  prt_timer prt_timer_inst (.sys_clk(sys_clk), .rst(rst),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .comp_uflow(comp_uflow), .irq(irq));

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  // pready sampled before this edge's updates land
  task ap(input logic w, input logic [9:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {a, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    // no local limit: only the watchdog ends a hung wait
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rv = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [9:0] a, input logic [7:0] d);
    ap(1'b1, a, d);
  endtask

  task rc(input logic [9:0] a, input logic [7:0] e);
    ap(1'b0, a, 8'h00);
    chk("read", {24'h0, e}, rv);
  endtask

  task setup(input logic [7:0] m, input logic [7:0] p, input logic [7:0] r);
    wr(IDX_CONTROL, 8'h00);
    wr(IDX_MODE, m);
    wr(IDX_PRESCALER, p);
    wr(IDX_PRIMARY, r);
    wr(IDX_IRQ_STAT, 8'h01);
    wr(IDX_CONTROL, 8'h01);
  endtask

  task t_reset;
    rc(IDX_PRIMARY, 8'hff);
    rc(IDX_PRESCALER, 8'hff);
    rc(IDX_CONTROL, 8'h00);
    rc(IDX_IRQ_STAT, 8'h00);
    // low bit is output level select, kept zero in timer mode
    wr(IDX_IO_CTRL, 8'hfe);
    rc(IDX_IO_CTRL, 8'h0e);
    wr(IDX_PRIMARY, 8'h00);
    rc(IDX_PRIMARY, 8'h00);
    ap(1'b0, 10'h000, 8'h00);
    chk("slverr", 32'h1, {31'h0, re});
  endtask

  // divide ratio (1+1)(3+1) = 8 ticks per divided source, (0+1)(1+1) = 2 for the companion
  task t_sources;
    int mul[3] = '{1, 2, 8};
    wr(IDX_ONESHOT, 8'hff);
    wr(IDX_SECONDARY, 8'h00);
    rc(IDX_SECONDARY, 8'h00);
    wr(IDX_IRQ_MASK, 8'h01);
    for (int s = 0; s < 3; s++) begin
      setup({2'b00, s[1:0], 4'h0}, 8'h01, 8'h03);
      repeat (3 * mul[s]) @(posedge sys_clk);
      rc(IDX_IRQ_STAT, 8'h00);
      repeat (10 * mul[s]) @(posedge sys_clk);
      rc(IDX_IRQ_STAT, 8'h01);
      chk("irq", 32'h1, {31'h0, irq});
    end
    wr(IDX_CONTROL, 8'h00);
    wr(IDX_IRQ_MASK, 8'h00);
    repeat (2) @(posedge sys_clk);
    chk("irq", 32'h0, {31'h0, irq});
    setup(8'h30, 8'h00, 8'h01);
    repeat (20) @(posedge sys_clk);
    rc(IDX_IRQ_STAT, 8'h00);
    repeat (2) begin
      comp_uflow <= 1'b1;
      @(posedge sys_clk);
      comp_uflow <= 1'b0;
      @(posedge sys_clk);
    end
    repeat (3) @(posedge sys_clk);
    rc(IDX_IRQ_STAT, 8'h01);
  endtask

  task t_stop;
    setup(8'h00, 8'h00, 8'hff);
    rc(IDX_CONTROL, 8'h03);
    ap(1'b0, IDX_PRIMARY, 8'h00);
    v = rv;
    repeat (20) @(posedge sys_clk);
    ap(1'b0, IDX_PRIMARY, 8'h00);
    chk("running", 32'h1, {31'h0, v !== rv});
    wr(IDX_CONTROL, 8'h00);
    ap(1'b0, IDX_PRIMARY, 8'h00);
    v = rv;
    repeat (20) @(posedge sys_clk);
    rc(IDX_PRIMARY, v[7:0]);
    wr(IDX_CONTROL, 8'h01);
    wr(IDX_CONTROL, 8'h05);
    rc(IDX_CONTROL, 8'h00);
  endtask

  // prescaler ff keeps the timer counter still for 256 cycles
  task t_running_write;
    setup(8'h08, 8'hff, 8'h10);
    wr(IDX_PRIMARY, 8'h80);
    ap(1'b0, IDX_PRIMARY, 8'h00);
    chk("reload only", 32'h10, rv);
    wr(IDX_MODE, 8'h00);
    wr(IDX_PRIMARY, 8'h80);
    rc(IDX_PRIMARY, 8'h10);
    repeat (300) @(posedge sys_clk);
    ap(1'b0, IDX_PRIMARY, 8'h00);
    chk("both", 32'h80, rv);
    wr(IDX_CONTROL, 8'h00);
  endtask

  task finish_test;
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    finish_test;
  end

  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, comp_uflow} = 4'h0;
    paddr = '0;
    pwdata = '0;
    error_cnt = 0;
    samples_checked = 0;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset;
    t_sources;
    t_stop;
    t_running_write;
    finish_test;
  end
endmodule
`default_nettype wire
